//--- src/gpm_pkg.sv
package gpm_pkg;
    // port indices, B through G
    localparam int NUM_PORTS = 6;
    localparam int PORT_B = 0;
    localparam int PORT_C = 1;
    localparam int PORT_D = 2;
    localparam int PORT_E = 3;
    localparam int PORT_F = 4;
    localparam int PORT_G = 5;
    localparam int PORT_W = 8;

    // address views
    localparam logic [15:0] IO_MAX = 16'h003F;
    localparam logic [15:0] DS_IO_OFFSET = 16'h0020;
    localparam logic [15:0] EXT_BASE = 16'h0060;

    // short io addresses
    localparam logic [15:0] IO_PORT_F_PIN = 16'h0000;
    localparam logic [15:0] IO_PORT_E_PIN = 16'h0001;
    localparam logic [15:0] IO_PORT_E_DIR = 16'h0002;
    localparam logic [15:0] IO_PORT_E_OUT = 16'h0003;
    localparam logic [15:0] IO_PORT_D_PIN = 16'h0010;
    localparam logic [15:0] IO_PORT_D_DIR = 16'h0011;
    localparam logic [15:0] IO_PORT_D_OUT = 16'h0012;
    localparam logic [15:0] IO_PORT_C_PIN = 16'h0013;
    localparam logic [15:0] IO_PORT_C_DIR = 16'h0014;
    localparam logic [15:0] IO_PORT_C_OUT = 16'h0015;
    localparam logic [15:0] IO_PORT_B_PIN = 16'h0016;

    // extended area, data-space addresses only
    localparam logic [15:0] DS_PORT_F_DIR = 16'h0061;
    localparam logic [15:0] DS_PORT_F_OUT = 16'h0062;
    localparam logic [15:0] DS_PORT_G_PIN = 16'h0063;
    localparam logic [15:0] DS_PORT_G_DIR = 16'h0064;
    localparam logic [15:0] DS_PORT_G_OUT = 16'h0065;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hFF;

    // implemented bits of output and direction, per port
    localparam logic [7:0] IMPL_MASK [0:NUM_PORTS-1] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F};
    // implemented bits of pin level, per port
    localparam logic [7:0] PIN_MASK [0:NUM_PORTS-1] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F};

    typedef enum logic [1:0] {
        GPM_KIND_NONE,
        GPM_KIND_PIN,
        GPM_KIND_DIR,
        GPM_KIND_OUT
    } gpm_kind_t;
endpackage : gpm_pkg

//--- src/gpm_port_regs.sv
`timescale 1ns/100ps

// Behaviour
// - io instructions decode only short addresses 0x00 to 0x3F.
// - data-space view places each port register at io address plus 0x20.
// - extended area from 0x60 reachable only by data-space accesses.
// - port B pin level, read-only, io 0x16, data 0x36.
// - port C output 0x15 and direction 0x14, read/write, reset zero.
// - legacy mode drives all port C pins push-pull from the output register, at zero during reset.
// - legacy port C drive holds without any clock edge.
// - legacy mode hides port F output and direction; port F input only.
// - port D output 0x12, direction 0x11, pin level 0x10.
// - port E output 0x03, direction 0x02, pin level 0x01, reset zero.
// - port F pin level at io 0x00, data 0x20, read-only.
// - port F output 0x62 and direction 0x61 only in extended area.
// - port G output 0x65 implements bits 4:0, reset zero.
// - port G direction 0x64 implements bits 4:0, reset zero.
// - global pull-up disable switches off every pull-up.
module gpm_port_regs
    import gpm_pkg::*;
#(
    parameter int PW = PORT_W
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic compat_mode,
    input wire logic global_pullup_disable,
    input wire logic [15:0] bus_addr,
    input wire logic bus_io_sel,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic bus_hit,
    input wire logic [NUM_PORTS-1:0][PW-1:0] pin_in,
    output logic [NUM_PORTS-1:0][PW-1:0] pin_out,
    output logic [NUM_PORTS-1:0][PW-1:0] pin_oe,
    output logic [NUM_PORTS-1:0][PW-1:0] pin_pu
);

    // synchroniser stages; pin levels carry no reset since their reset value is undefined
    logic [NUM_PORTS-1:0][PW-1:0] pin_s1_q;
    logic [NUM_PORTS-1:0][PW-1:0] pin_s2_q;
    logic compat_s1_q;
    logic compat_s2_q;

    // register state and per-port write enables
    logic [NUM_PORTS-1:0][PW-1:0] out_q;
    logic [NUM_PORTS-1:0][PW-1:0] dir_q;
    logic [NUM_PORTS-1:0] wr_out_en;
    logic [NUM_PORTS-1:0] wr_dir_en;

    // address decode and legacy mode flags
    logic [15:0] ds_addr;
    logic addr_ok;
    logic io_ext;
    logic bus_req;
    logic legacy_c;
    logic legacy_f;
    gpm_kind_t kind;
    gpm_kind_t acc_kind;
    int unsigned port_sel;

    // pin control ahead of the legacy overrides
    logic [PW-1:0] pu_gate;
    logic [NUM_PORTS-1:0][PW-1:0] oe_norm;
    logic [NUM_PORTS-1:0][PW-1:0] drv_norm;
    logic [NUM_PORTS-1:0][PW-1:0] pu_norm;
    logic [NUM_PORTS-1:0][PW-1:0] pin_lvl;

    // read path
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic hit_q;

    // two-flop pin synchroniser; only the second stage is read
    always_ff @(posedge clk_sys) begin
        pin_s1_q <= pin_in;
        pin_s2_q <= pin_s1_q;
    end

    // fuse synchroniser for decode and port F
    always_ff @(posedge clk_sys) begin
        compat_s1_q <= compat_mode;
        compat_s2_q <= compat_s1_q;
    end

    // fold both views onto the data-space address
    always_comb begin
        ds_addr = bus_addr;
        addr_ok = 1'b1;
        if (bus_io_sel) begin
            addr_ok = (bus_addr <= IO_MAX);
            ds_addr = bus_addr + DS_IO_OFFSET;
        end
    end

    // any strobe; a refused place still sees the request but never hits
    assign bus_req = bus_rd || bus_wr;

    // io view must never reach the extended area, whatever the range limit says
    assign io_ext = bus_io_sel && (ds_addr >= EXT_BASE);

    // port C takes the raw fuse so its drive needs no clock edge; a static fuse makes this safe
    assign legacy_c = compat_mode;
    assign legacy_f = compat_s2_q;

    // register decode; io view tops out at 0x5F so extended area is unreachable there
    always_comb begin
        kind = GPM_KIND_NONE;
        port_sel = PORT_B;
        case (ds_addr)
            IO_PORT_F_PIN + DS_IO_OFFSET: begin
                kind = GPM_KIND_PIN;
                port_sel = PORT_F;
            end
            IO_PORT_E_PIN + DS_IO_OFFSET: begin
                kind = GPM_KIND_PIN;
                port_sel = PORT_E;
            end
            IO_PORT_E_DIR + DS_IO_OFFSET: begin
                kind = GPM_KIND_DIR;
                port_sel = PORT_E;
            end
            IO_PORT_E_OUT + DS_IO_OFFSET: begin
                kind = GPM_KIND_OUT;
                port_sel = PORT_E;
            end
            IO_PORT_D_PIN + DS_IO_OFFSET: begin
                kind = GPM_KIND_PIN;
                port_sel = PORT_D;
            end
            IO_PORT_D_DIR + DS_IO_OFFSET: begin
                kind = GPM_KIND_DIR;
                port_sel = PORT_D;
            end
            IO_PORT_D_OUT + DS_IO_OFFSET: begin
                kind = GPM_KIND_OUT;
                port_sel = PORT_D;
            end
            IO_PORT_C_PIN + DS_IO_OFFSET: begin
                kind = GPM_KIND_PIN;
                port_sel = PORT_C;
            end
            IO_PORT_C_DIR + DS_IO_OFFSET: begin
                kind = GPM_KIND_DIR;
                port_sel = PORT_C;
            end
            IO_PORT_C_OUT + DS_IO_OFFSET: begin
                kind = GPM_KIND_OUT;
                port_sel = PORT_C;
            end
            IO_PORT_B_PIN + DS_IO_OFFSET: begin
                kind = GPM_KIND_PIN;
                port_sel = PORT_B;
            end
            DS_PORT_F_DIR: begin
                kind = GPM_KIND_DIR;
                port_sel = PORT_F;
            end
            DS_PORT_F_OUT: begin
                kind = GPM_KIND_OUT;
                port_sel = PORT_F;
            end
            DS_PORT_G_PIN: begin
                kind = GPM_KIND_PIN;
                port_sel = PORT_G;
            end
            DS_PORT_G_DIR: begin
                kind = GPM_KIND_DIR;
                port_sel = PORT_G;
            end
            DS_PORT_G_OUT: begin
                kind = GPM_KIND_OUT;
                port_sel = PORT_G;
            end
            default: begin
                kind = GPM_KIND_NONE;
                port_sel = PORT_B;
            end
        endcase
    end

    // refusal stage: out of range, extended area via io, legacy port F registers
    always_comb begin
        acc_kind = kind;
        if (!addr_ok) begin
            acc_kind = GPM_KIND_NONE;
        end
        if (io_ext) begin
            acc_kind = GPM_KIND_NONE;
        end
        // legacy mode: port F output and direction vanish from the map
        if (legacy_f && port_sel == PORT_F && kind != GPM_KIND_PIN) begin
            acc_kind = GPM_KIND_NONE;
        end
    end

    // per-port registers, pin control and masked pin levels
    assign pu_gate = {PW{~global_pullup_disable}};
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        // plain per-port enables keep the register processes free of decode
        assign wr_out_en[p] = bus_wr && acc_kind == GPM_KIND_OUT && port_sel == p;
        assign wr_dir_en[p] = bus_wr && acc_kind == GPM_KIND_DIR && port_sel == p;

        // output data register; unimplemented bits never store
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                out_q[p] <= REG_RESET[PW-1:0];
            end else if (wr_out_en[p]) begin
                out_q[p] <= bus_wdata[PW-1:0] & IMPL_MASK[p][PW-1:0];
            end
        end

        // direction register, same reset and masking
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                dir_q[p] <= REG_RESET[PW-1:0];
            end else if (wr_dir_en[p]) begin
                dir_q[p] <= bus_wdata[PW-1:0] & IMPL_MASK[p][PW-1:0];
            end
        end

        // ordinary pin control; drive is masked so an input pin shows no stale value
        always_comb begin
            oe_norm[p] = dir_q[p];
            drv_norm[p] = out_q[p] & dir_q[p];
            pu_norm[p] = ~dir_q[p] & out_q[p] & pu_gate;
        end

        // pin level as read back, direction plays no part
        assign pin_lvl[p] = pin_s2_q[p] & PIN_MASK[p][PW-1:0];

        // legacy port C: raw fuse level and reset force zero drive with no clock needed
        if (p == PORT_C) begin : g_legacy_c
            always_comb begin
                if (legacy_c) begin
                    pin_oe[p] = ALL_ONES[PW-1:0];
                    pin_out[p] = srst ? REG_RESET[PW-1:0] : out_q[p];
                    pin_pu[p] = REG_RESET[PW-1:0];
                end else begin
                    pin_oe[p] = oe_norm[p];
                    pin_out[p] = drv_norm[p];
                    pin_pu[p] = pu_norm[p];
                end
            end
        end else if (p == PORT_F) begin : g_legacy_f
            // synced fuse is enough here, port F only hides its registers and turns its pins to input
            always_comb begin
                if (legacy_f) begin
                    pin_oe[p] = REG_RESET[PW-1:0];
                    pin_out[p] = REG_RESET[PW-1:0];
                    pin_pu[p] = REG_RESET[PW-1:0];
                end else begin
                    pin_oe[p] = oe_norm[p];
                    pin_out[p] = drv_norm[p];
                    pin_pu[p] = pu_norm[p];
                end
            end
        end else begin : g_plain
            always_comb begin
                pin_oe[p] = oe_norm[p];
                pin_out[p] = drv_norm[p];
                pin_pu[p] = pu_norm[p];
            end
        end
    end

    // read mux; unmapped or refused addresses read zero
    always_comb begin
        rdata_d = READ_IDLE;
        case (acc_kind)
            GPM_KIND_PIN: rdata_d = pin_lvl[port_sel];
            GPM_KIND_DIR: rdata_d = dir_q[port_sel];
            GPM_KIND_OUT: rdata_d = out_q[port_sel];
            default: rdata_d = READ_IDLE;
        endcase
    end

    // read data registered one cycle after the strobe, zero on idle cycles
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_q <= READ_IDLE;
        end else if (bus_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= READ_IDLE;
        end
    end

    // hit tells software a refused place apart from a register that reads zero
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= bus_req && acc_kind != GPM_KIND_NONE;
        end
    end

    // registered answer straight to the ports
    assign bus_rdata = rdata_q;
    assign bus_hit = hit_q;

endmodule : gpm_port_regs

//--- testbench/gpm_port_regs_props.sv
`timescale 1ns/100ps
// pin and bus relations of the port block
module gpm_port_regs_chk
    import gpm_pkg::*;
#(
    parameter int PW = PORT_W
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic compat_mode,
    input wire logic global_pullup_disable,
    input wire logic [15:0] bus_addr,
    input wire logic bus_io_sel,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_hit,
    input wire logic [NUM_PORTS-1:0][PW-1:0] pin_in,
    input wire logic [NUM_PORTS-1:0][PW-1:0] pin_out,
    input wire logic [NUM_PORTS-1:0][PW-1:0] pin_oe,
    input wire logic [NUM_PORTS-1:0][PW-1:0] pin_pu
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_io_range; (bus_rd || bus_wr) && bus_io_sel && bus_addr > 16'h003F |=> !bus_hit; endproperty
    a_io_range: assert property (p_io_range) else $error("io access above range answered");
    property p_ext_hit; bus_wr && !bus_io_sel && bus_addr == 16'h0065 |=> bus_hit; endproperty
    a_ext_hit: assert property (p_ext_hit) else $error("extended write not taken");
    property p_c_dir; bus_wr && bus_io_sel && bus_addr == 16'h0014 && !compat_mode |=> pin_oe[1] == $past(bus_wdata);
    endproperty
    a_c_dir: assert property (p_c_dir) else $error("port c enable not from write");
    property p_legacy_c; compat_mode |-> pin_oe[1] == 8'hFF; endproperty
    a_legacy_c: assert property (p_legacy_c) else $error("legacy port c not driven");
    // must hold while reset is still applied
    property p_legacy_rst; disable iff (1'b0) compat_mode && srst |-> pin_out[1] == 8'h00 && pin_oe[1] == 8'hFF;
    endproperty
    a_legacy_rst: assert property (p_legacy_rst) else $error("legacy port c not zero in reset");
    property p_legacy_f; compat_mode && $past(compat_mode, 3) |-> pin_oe[4] == 8'h00 && pin_pu[4] == 8'h00; endproperty
    a_legacy_f: assert property (p_legacy_f) else $error("legacy port f not input");
    property p_g_dir; bus_wr && !bus_io_sel && bus_addr == 16'h0064 |=> pin_oe[5] == ($past(bus_wdata) & 8'h1F);
    endproperty
    a_g_dir: assert property (p_g_dir) else $error("port g enable wrong");
    property p_pud; global_pullup_disable |-> pin_pu == '0; endproperty
    a_pud: assert property (p_pud) else $error("pull-up on while disabled");
    c_c_dir: cover property (bus_wr && bus_io_sel && bus_addr == 16'h0014);
    c_legacy: cover property (compat_mode && bus_wr);
    c_refused: cover property (bus_io_sel && bus_addr > 16'h003F && bus_rd);
endmodule : gpm_port_regs_chk

bind gpm_port_regs gpm_port_regs_chk #(.PW(PW)) u_chk (.clk_sys(clk_sys), .srst(srst), .compat_mode(compat_mode),
    .global_pullup_disable(global_pullup_disable), .bus_addr(bus_addr), .bus_io_sel(bus_io_sel), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_hit(bus_hit), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu));

//--- testbench/tb.sv
`timescale 1ns/100ps
// self-checking bench for the port register block
module tb;
    import gpm_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic compat_mode = 1'b0;
    logic global_pullup_disable = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic bus_io_sel = 1'b0;
    logic bus_rd = 1'b0;
    logic bus_wr = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata;
    logic bus_hit;
    logic [NUM_PORTS-1:0][PORT_W-1:0] pin_in = '0;
    logic [NUM_PORTS-1:0][PORT_W-1:0] pin_out;
    logic [NUM_PORTS-1:0][PORT_W-1:0] pin_oe;
    logic [NUM_PORTS-1:0][PORT_W-1:0] pin_pu;
    int mismatches = 0;
    int samples_checked = 0;

    always #12.5 clk_sys = ~clk_sys;

    gpm_port_regs uut (.clk_sys(clk_sys), .srst(srst), .compat_mode(compat_mode),
        .global_pullup_disable(global_pullup_disable), .bus_addr(bus_addr), .bus_io_sel(bus_io_sel), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_hit(bus_hit), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu));

    task automatic complete_run;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one strobe cycle; the answer stands only in the following cycle
    task automatic acc(input logic io, input logic [15:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_sys);
        bus_io_sel <= io;
        bus_addr <= a;
        bus_wr <= w;
        bus_rd <= !w;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        bus_wr <= 1'b0;
        #1;
    endtask : acc

    task automatic rd(input logic io, input logic [15:0] a, input logic [7:0] exp, input logic h);
        acc(io, a, 1'b0, 8'h00);
        chk("read data", bus_rdata, exp);
        chk("hit", {7'h00, bus_hit}, {7'h00, h});
    endtask : rd

    // every read/write register leaves reset at zero
    task automatic t_reset;
        logic [15:0] ra [10] = '{16'h0022, 16'h0023, 16'h0031, 16'h0032, 16'h0034, 16'h0035, 16'h0061, 16'h0062,
            16'h0064, 16'h0065};
        foreach (ra[i]) rd(1'b0, ra[i], 8'h00, 1'b1);
    endtask : t_reset

    // io writes seen again through both address views
    task automatic t_map;
        logic [15:0] ia [6] = '{16'h0002, 16'h0003, 16'h0011, 16'h0012, 16'h0014, 16'h0015};
        foreach (ia[i]) begin
            acc(1'b1, ia[i], 1'b1, 8'h5A + 8'(i));
            rd(1'b1, ia[i], 8'h5A + 8'(i), 1'b1);
            rd(1'b0, ia[i] + 16'h0020, 8'h5A + 8'(i), 1'b1);
        end
    endtask : t_map

    // pin levels, whatever the direction bits say
    task automatic t_pins;
        logic [15:0] pa [6] = '{16'h0036, 16'h0033, 16'h0030, 16'h0021, 16'h0020, 16'h0063};
        logic [7:0] ex [6] = '{8'hC3, 8'h96, 8'h3C, 8'hA5, 8'h69, 8'h07};
        @(posedge clk_sys);
        pin_in <= {8'hE7, 8'h69, 8'hA5, 8'h3C, 8'h96, 8'hC3};
        repeat (3) @(posedge clk_sys);
        foreach (pa[i]) rd(1'b0, pa[i], ex[i], 1'b1);
        rd(1'b1, 16'h0016, 8'hC3, 1'b1);
        rd(1'b1, 16'h0000, 8'h69, 1'b1);
    endtask : t_pins

    // read-only, out-of-range and extended places
    task automatic t_refuse;
        acc(1'b1, 16'h0016, 1'b1, 8'h00);
        rd(1'b1, 16'h0016, 8'hC3, 1'b1);
        acc(1'b1, 16'h0042, 1'b1, 8'hFF);
        chk("io above range hit", {7'h00, bus_hit}, 8'h00);
        rd(1'b1, 16'h0045, 8'h00, 1'b0);
        rd(1'b0, 16'h0062, 8'h00, 1'b1);
    endtask : t_refuse

    // port g five bits, drive and pull-ups, then global disable
    task automatic t_drive;
        acc(1'b0, 16'h0065, 1'b1, 8'hFF);
        acc(1'b0, 16'h0064, 1'b1, 8'hF3);
        rd(1'b0, 16'h0065, 8'h1F, 1'b1);
        rd(1'b0, 16'h0064, 8'h13, 1'b1);
        chk("g drive", pin_out[5], 8'h13);
        chk("g pull-up", pin_pu[5], 8'h0C);
        chk("e pull-up", pin_pu[3], 8'h01);
        @(posedge clk_sys);
        global_pullup_disable <= 1'b1;
        #1;
        chk("g pull-up off", pin_pu[5], 8'h00);
        chk("e pull-up off", pin_pu[3], 8'h00);
        @(posedge clk_sys);
        global_pullup_disable <= 1'b0;
    endtask : t_drive

    // legacy mode: port f input only with stored values hidden, then port c driven low with no edge needed
    task automatic t_legacy;
        acc(1'b0, 16'h0061, 1'b1, 8'h0F);
        acc(1'b0, 16'h0062, 1'b1, 8'hFF);
        chk("f enable before", pin_oe[4], 8'h0F);
        chk("f pull-up before", pin_pu[4], 8'hF0);
        @(posedge clk_sys);
        compat_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("f enable", pin_oe[4], 8'h00);
        chk("f pull-up", pin_pu[4], 8'h00);
        rd(1'b0, 16'h0020, 8'h69, 1'b1);
        acc(1'b0, 16'h0062, 1'b1, 8'hFF);
        chk("f out hit", {7'h00, bus_hit}, 8'h00);
        rd(1'b0, 16'h0061, 8'h00, 1'b0);
        @(posedge clk_sys);
        srst <= 1'b1;
        #1;
        chk("c enable", pin_oe[1], 8'hFF);
        chk("c drive", pin_out[1], 8'h00);
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd(1'b1, 16'h0014, 8'h00, 1'b1);
    endtask : t_legacy

    // main sequence after six reset cycles
    initial begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset;
        t_map;
        t_pins;
        t_refuse;
        t_drive;
        t_legacy;
        complete_run;
    end

    // watchdog, far beyond the roughly 130 cycles needed
    initial begin
        repeat (3000) @(posedge clk_sys);
        mismatches++;
        complete_run;
    end
endmodule : tb
